// *** hdl/usb_pin_pkg.sv ***
// Shared constants and types for the USB transceiver pin logic.
package usb_pin_pkg;

  // System clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 4;

  // Power-on pulse width, rounded up to whole cycles.
  localparam int POR_PULSE_WIDTH_NS = 200;
  localparam int POR_PULSE_CYCLES_I = (POR_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] POR_PULSE_CYCLES = POR_PULSE_CYCLES_I[11:0];

  // Supply dip that re-arms the power-on pulse; longer than this re-arms.
  localparam int DIP_LIMIT_NS = 11000;
  localparam int DIP_LIMIT_CYCLES_I = (DIP_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] DIP_LIMIT_CYCLES = DIP_LIMIT_CYCLES_I[11:0];

  // Two-wire bus address with the select bit clear.
  localparam logic [6:0] BUS_ADDR_BASE = 7'h2C;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // Control register fields and reset value.
  localparam int CTRL_ENCODED_BIT = 0;
  localparam int CTRL_SUSPEND_BIT = 1;
  localparam int CTRL_PUMP_EN_BIT = 2;
  localparam int CTRL_PUMP_ON_BIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status register fields.
  localparam int STAT_ADDR_SEL_BIT = 0;
  localparam int STAT_POR_BIT = 1;
  localparam int STAT_RECEIVE_BIT = 2;
  localparam int STAT_DEV_RESET_BIT = 3;
  localparam int STAT_BUS_ADDR_LSB = 8;

  // Power-on pulse generator states.
  typedef enum logic [1:0] {
    POR_ARMED,
    POR_PULSING,
    POR_RUNNING
  } por_state_t;

endpackage : usb_pin_pkg

// *** hdl/por_pulse_gen.sv ***
// Power-on reset pulse generator with supply dip filter.
`timescale 1ns/100ps
module por_pulse_gen
  import usb_pin_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic supplyOk,
  output logic porPulse
);

  por_state_t state;
  logic [11:0] pulseCount;
  logic [11:0] lowCount;

  // Pulse starts on supply above trip while armed; long dips re-arm.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state <= POR_ARMED;
      porPulse <= 1'b0;
      pulseCount <= 12'h000;
      lowCount <= 12'h000;
    end
    else
    begin
      if (supplyOk)
      begin
        lowCount <= 12'h000;
      end
      else if (lowCount != 12'hFFF)
      begin
        lowCount <= lowCount + 12'h001;
      end
      case (state)
        POR_ARMED:
        begin
          if (supplyOk)
          begin
            state <= POR_PULSING;
            porPulse <= 1'b1;
            pulseCount <= 12'h001;
          end
        end
        POR_PULSING:
        begin
          if (pulseCount >= POR_PULSE_CYCLES)
          begin
            state <= POR_RUNNING;
            porPulse <= 1'b0;
          end
          else
          begin
            pulseCount <= pulseCount + 12'h001;
          end
        end
        default:
        begin
          // Only a dip longer than the limit re-arms; shorter ones are ignored.
          if (!supplyOk && lowCount >= DIP_LIMIT_CYCLES)
          begin
            state <= POR_ARMED;
          end
        end
      endcase
    end
  end

endmodule : por_pulse_gen

// *** hdl/addr_strap_latch.sv ***
// Address-select strap latch taken on the external reset release.
`timescale 1ns/100ps
module addr_strap_latch
  import usb_pin_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic porPulse,
  input wire logic extResetN,
  input wire logic strapIn,
  output logic addrSelect
);

  logic prevResetN;

  // Remembers the reset pin to find its rising edge.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      prevResetN <= 1'b1;
    end
    else
    begin
      prevResetN <= extResetN;
    end
  end

  // Power-on clears the bit and wins over a reset pin rising edge, which otherwise samples the strap.
  always_ff @(posedge sys_clk)
  begin
    if (rst || porPulse)
    begin
      addrSelect <= 1'b0;
    end
    else if (extResetN && !prevResetN)
    begin
      addrSelect <= strapIn;
    end
  end

endmodule : addr_strap_latch

// *** hdl/otg_pin_logic.sv ***
// Pin mapping logic of a full/low-speed USB transceiver with register access.
//
// What this block does
// - Single-ended mode, enabled, not suspended: each line follows its own input.
// - Encoded mode drives data and its complement; single-ended passes both inputs.
// - Encoded mode, not suspended, with force-zero high drives both lines low.
// - In suspend the data/plus input drives both lines, in any mode.
// - Driver floats while output enable is high or any reset is active.
// - Encoded receive puts the differential result on data pin and receive output.
// - Single-ended receive puts the differential result only on receive output.
// - Encoded receive flags zero on both lines low; equal lines hold the last value.
// - Single-ended receive mirrors each line; equal lines hold the differential result.
// - Encoded suspend: data follows plus line, zero flag on both lines low.
// - An internal power-on pulse of 200 ns starts when the supply rises.
// - Only supply dips longer than 11 us start a new power-on pulse.
// - The reset pin rising edge samples the strap pin into the select bit.
// - Bus address is 2C hex with select low and 2D hex with it high.
// - After power-on the select bit is zero until a reset edge samples.
// - Pump switch is active high with select low and active low with it high.
// - Pump switch pin is driven only while its enable bit is one.
// - Suspend powers down the differential receiver; single-ended receivers stay.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module otg_pin_logic
  import usb_pin_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  // Classic Wishbone slave.
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatWr,
  output logic [31:0] wbDatRd,
  output logic wbAck,
  // Controller side.
  input wire logic extResetN,
  input wire logic outEnableN,
  input wire logic dataOrPlusPinIn,
  output logic dataOrPlusPinOut,
  output logic dataOrPlusPinOe,
  input wire logic zeroOrMinusPinIn,
  output logic zeroOrMinusPinOut,
  output logic zeroOrMinusPinOe,
  output logic diffReceiveOut,
  input wire logic addrStrapSwitchPinIn,
  output logic addrStrapSwitchPinOut,
  output logic addrStrapSwitchPinOe,
  // Supply detector: high while the core supply is above the trip level.
  input wire logic supplyOk,
  // Bus lines.
  input wire logic dpIn,
  output logic dpOut,
  output logic dpOe,
  input wire logic dmIn,
  output logic dmOut,
  output logic dmOe
);

  // Control register and its named bits.
  logic [3:0] ctrl;
  logic encodedIfSelect;
  logic suspend;
  logic pumpSwitchOutEn;
  logic pumpSwitchOn;
  // Internal resets and the latched select bit.
  logic porPulse;
  logic addrSelect;
  logic deviceReset;
  logic driverActive;
  // Transmit and receive selection.
  logic next_dpOut;
  logic next_dmOut;
  logic linesDiffer;
  logic next_receive;
  logic next_dataOut;
  logic next_zeroOut;
  // Register access.
  logic [6:0] busAddress;
  logic wbReq;
  logic [31:0] statusWord;

  // Control bits as named views of the control register.
  assign encodedIfSelect = ctrl[CTRL_ENCODED_BIT];
  assign suspend = ctrl[CTRL_SUSPEND_BIT];
  assign pumpSwitchOutEn = ctrl[CTRL_PUMP_EN_BIT];
  assign pumpSwitchOn = ctrl[CTRL_PUMP_ON_BIT];

  // Power-on pulse generation and dip filtering.
  por_pulse_gen u_por (
    .sys_clk(sys_clk),
    .rst(rst),
    .supplyOk(supplyOk),
    .porPulse(porPulse)
  );

  // Address-select strap latch.
  // The strap is taken from the pin's input side, whatever drives it at that moment.
  addr_strap_latch u_strap (
    .sys_clk(sys_clk),
    .rst(rst),
    .porPulse(porPulse),
    .extResetN(extResetN),
    .strapIn(addrStrapSwitchPinIn),
    .addrSelect(addrSelect)
  );

  // The select bit forms the address LSB.
  assign busAddress = BUS_ADDR_BASE | {6'h00, addrSelect};

  // Device reset combines the reset pin with the internal power-on pulse.
  // It only floats the line drivers; receive paths and registers keep running.
  assign deviceReset = !extResetN || porPulse;
  assign driverActive = !deviceReset && !outEnableN;

  // Transmit line selection, evaluated directly from inputs and bits.
  // Suspend is tested first: it overrides the mode, so force-zero has no effect there.
  // The defaults are the single-ended case, where each line copies its own input.
  always_comb
  begin
    next_dpOut = dataOrPlusPinIn;
    next_dmOut = zeroOrMinusPinIn;
    if (suspend)
    begin
      // Both lines copy the data input; the mode bit is ignored.
      next_dpOut = dataOrPlusPinIn;
      next_dmOut = dataOrPlusPinIn;
    end
    else if (encodedIfSelect)
    begin
      if (zeroOrMinusPinIn)
      begin
        // Force-zero wins over the data input.
        next_dpOut = 1'b0;
        next_dmOut = 1'b0;
      end
      else
      begin
        // Data and its complement form the differential pair.
        next_dpOut = dataOrPlusPinIn;
        next_dmOut = !dataOrPlusPinIn;
      end
    end
  end

  // Bus line data, registered from the transmit selection.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dpOut <= 1'b0;
      dmOut <= 1'b0;
    end
    else
    begin
      dpOut <= next_dpOut;
      dmOut <= next_dmOut;
    end
  end

  // Bus line enables; either reset source floats both lines together at the next clock edge.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dpOe <= 1'b0;
      dmOe <= 1'b0;
    end
    else
    begin
      dpOe <= driverActive;
      dmOe <= driverActive;
    end
  end

  // Differential result: follows DP while the lines differ, else holds.
  // In suspend the differential receiver is off and the result just holds.
  // Equal lines, both low or both high, carry no differential information.
  assign linesDiffer = dpIn != dmIn;
  assign next_receive = (!suspend && linesDiffer) ? dpIn : diffReceiveOut;

  // Receive pin selection for both interface modes and suspend.
  // Single-ended mode mirrors each line in every suspend state.
  always_comb
  begin
    next_dataOut = dpIn;
    next_zeroOut = dmIn;
    if (encodedIfSelect)
    begin
      // The received-zero flag is set only for both lines low.
      next_zeroOut = !dpIn && !dmIn;
      if (suspend)
      begin
        next_dataOut = dpIn;
      end
      else
      begin
        next_dataOut = next_receive;
      end
    end
  end

  // Held differential output, updated from the bus lines.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      diffReceiveOut <= 1'b0;
    end
    else
    begin
      diffReceiveOut <= next_receive;
    end
  end

  // Controller-side pin data from the receive selection.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dataOrPlusPinOut <= 1'b0;
      zeroOrMinusPinOut <= 1'b0;
    end
    else
    begin
      dataOrPlusPinOut <= next_dataOut;
      zeroOrMinusPinOut <= next_zeroOut;
    end
  end

  // Controller-side pins turn round with the active-low output enable.
  // While the controller transmits, it owns these pins and they float here.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dataOrPlusPinOe <= 1'b0;
      zeroOrMinusPinOe <= 1'b0;
    end
    else
    begin
      dataOrPlusPinOe <= outEnableN;
      zeroOrMinusPinOe <= outEnableN;
    end
  end

  // Pump switch level; the select bit sets its polarity.
  // Without a reset pin pulse the select bit stays low, so active high.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      addrStrapSwitchPinOut <= 1'b0;
    end
    else
    begin
      addrStrapSwitchPinOut <= pumpSwitchOn ^ addrSelect;
    end
  end

  // Pump switch driver enable; while it is low the shared pin is only an input.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      addrStrapSwitchPinOe <= 1'b0;
    end
    else
    begin
      addrStrapSwitchPinOe <= pumpSwitchOutEn;
    end
  end

  // Read view of the block state.
  // The bus address is read back so software can see the latched select bit.
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[STAT_ADDR_SEL_BIT] = addrSelect;
    statusWord[STAT_POR_BIT] = porPulse;
    statusWord[STAT_RECEIVE_BIT] = diffReceiveOut;
    statusWord[STAT_DEV_RESET_BIT] = deviceReset;
    statusWord[STAT_BUS_ADDR_LSB +: 7] = busAddress;
  end

  // Wishbone handshake: one wait cycle, then ack for one cycle.
  // Ack is a registered pulse, so it never runs on into the next request.
  assign wbReq = wbCyc && wbStb;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wbAck <= 1'b0;
    end
    else
    begin
      wbAck <= wbReq && !wbAck;
    end
  end

  // Read data captured with the ack; unmapped offsets read zero.
  // Loading on the taking edge means the data stand when ack is sampled.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wbDatRd <= 32'h0000_0000;
    end
    else if (wbReq && !wbAck && !wbWe)
    begin
      if (wbAdr == CTRL_OFFSET)
      begin
        wbDatRd <= {28'h0000000, ctrl};
      end
      else if (wbAdr == STATUS_OFFSET)
      begin
        wbDatRd <= statusWord;
      end
      else
      begin
        wbDatRd <= 32'h0000_0000;
      end
    end
  end

  // Control register write at the edge where the master sees ack.
  // Only byte lane 0 holds control bits; the other lanes are ignored.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl <= CTRL_RESET;
    end
    else if (wbReq && wbAck && wbWe && wbSel[0])
    begin
      if (wbAdr == CTRL_OFFSET)
      begin
        ctrl <= wbDatWr[3:0];
      end
    end
  end

endmodule : otg_pin_logic

// *** test/otg_pin_logic_checker.sv ***
// Concurrent checks on the ports of the transceiver pin logic.
`timescale 1ns/100ps
module otg_pin_logic_checker
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic extResetN,
  input wire logic outEnableN,
  input wire logic dataOrPlusPinIn,
  input wire logic zeroOrMinusPinIn,
  input wire logic dataOrPlusPinOe,
  input wire logic zeroOrMinusPinOe,
  input wire logic diffReceiveOut,
  input wire logic dpIn,
  input wire logic dmIn,
  input wire logic dpOut,
  input wire logic dpOe,
  input wire logic dmOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Bus handshake: one registered acknowledge per request.
  AST_ACK_ONE: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wbAck |=> !wbAck)
    else $error("ack longer than one cycle");
  AST_ACK_NOREQ: assert property (!(wbCyc && wbStb) |=> !wbAck)
    else $error("ack without request");
  // Line drivers float when not enabled or held in reset.
  AST_OE_OFF: assert property (outEnableN || !extResetN |=> !dpOe && !dmOe)
    else $error("line driven while disabled");
  AST_DP_DM_OE: assert property (dpOe == dmOe)
    else $error("line enables differ");
  AST_RX_PIN_OE: assert property (!$past(rst) |-> dataOrPlusPinOe == $past(outEnableN) && zeroOrMinusPinOe == $past(outEnableN))
    else $error("controller pin enable wrong");
  // Equal lines leave the differential result unchanged.
  AST_DIFF_HOLD: assert property (dpIn == dmIn |=> $stable(diffReceiveOut))
    else $error("receive result changed on equal lines");
  AST_TX_DATA: assert property (dpOe |-> dpOut == $past(dataOrPlusPinIn) || !dpOut && $past(zeroOrMinusPinIn))
    else $error("plus line not from data input");
endmodule : otg_pin_logic_checker

bind otg_pin_logic otg_pin_logic_checker otg_pin_logic_checker_inst (.sys_clk, .rst, .wbCyc,
  .wbStb, .wbAck, .extResetN, .outEnableN, .dataOrPlusPinIn, .zeroOrMinusPinIn, .dataOrPlusPinOe,
  .zeroOrMinusPinOe, .diffReceiveOut, .dpIn, .dmIn, .dpOut, .dpOe, .dmOe);

// *** test/usb_ctrl_model.sv ***
// Behavioural serial engine on the controller side of the transceiver.
`timescale 1ns/100ps
module usb_ctrl_model
(
  input wire logic sys_clk,
  input wire logic dataOrPlusPinOut,
  input wire logic dataOrPlusPinOe,
  input wire logic zeroOrMinusPinOut,
  input wire logic zeroOrMinusPinOe,
  output logic dataOrPlusPinIn,
  output logic zeroOrMinusPinIn,
  output logic outEnableN,
  output logic extResetN
);
  logic txData = 1'b0;
  logic txZero = 1'b0;
  initial outEnableN = 1'b1;
  initial extResetN = 1'b1;
  // Each pin shows the device while it drives, else the controller level.
  assign dataOrPlusPinIn = dataOrPlusPinOe ? dataOrPlusPinOut : txData;
  assign zeroOrMinusPinIn = zeroOrMinusPinOe ? zeroOrMinusPinOut : txZero;
  // Drives a line state with the transmitter enabled.
  task automatic send(input logic d, input logic z);
    @(posedge sys_clk);
    outEnableN <= 1'b0;
    txData <= d;
    txZero <= z;
  endtask : send
  // Stops transmitting; released lines show the inverse of their last level.
  task automatic release_bus();
    @(posedge sys_clk);
    outEnableN <= 1'b1;
    txData <= ~txData;
    txZero <= ~txZero;
  endtask : release_bus
  // Pulses the reset pin low so the strap level is taken on its release.
  task automatic reset_pulse();
    @(posedge sys_clk);
    extResetN <= 1'b0;
    repeat (3) @(posedge sys_clk);
    extResetN <= 1'b1;
  endtask : reset_pulse
endmodule : usb_ctrl_model

// *** test/tb_top.sv ***
// Self-checking bench for the transceiver pin logic.
`timescale 1ns/100ps
module tb_top;
  import usb_pin_pkg::*;
  logic sys_clk, rst, wbCyc, wbStb, wbWe, wbAck, supplyOk, busDp, busDm, strapDrive, diff_receive_out;
  logic extResetN, outEnableN, dataOrPlusPinIn, dataOrPlusPinOut, dataOrPlusPinOe;
  logic zeroOrMinusPinIn, zeroOrMinusPinOut, zeroOrMinusPinOe, diffReceiveOut;
  logic addrStrapSwitchPinIn, addrStrapSwitchPinOut, addrStrapSwitchPinOe;
  logic dpIn, dpOut, dpOe, dmIn, dmOut, dmOe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatWr, wbDatRd, rd;
  int num_errors, checks;

  // Bus and strap wires resolve the device driver against the far side.
  assign dpIn = dpOe ? dpOut : busDp;
  assign dmIn = dmOe ? dmOut : busDm;
  assign addrStrapSwitchPinIn = addrStrapSwitchPinOe ? addrStrapSwitchPinOut : strapDrive;

  otg_pin_logic otg_pin_logic_inst (.sys_clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
    .wbDatWr, .wbDatRd, .wbAck, .extResetN, .outEnableN, .dataOrPlusPinIn, .dataOrPlusPinOut,
    .dataOrPlusPinOe, .zeroOrMinusPinIn, .zeroOrMinusPinOut, .zeroOrMinusPinOe, .diffReceiveOut,
    .addrStrapSwitchPinIn, .addrStrapSwitchPinOut, .addrStrapSwitchPinOe, .supplyOk, .dpIn,
    .dpOut, .dpOe, .dmIn, .dmOut, .dmOe);
  usb_ctrl_model usb_ctrl_model_inst (.sys_clk, .dataOrPlusPinOut, .dataOrPlusPinOe,
    .zeroOrMinusPinOut, .zeroOrMinusPinOe, .dataOrPlusPinIn, .zeroOrMinusPinIn, .outEnableN,
    .extResetN);

  // Free-running 250 MHz clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Counts a comparison and reports a mismatch.
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : cmp

  // One classic Wishbone cycle, entered right after a rising edge.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatWr <= dat;
    do
    begin
      @(posedge sys_clk);
    end
    while (wbAck !== 1'b1);
    rd = wbDatRd;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sys_clk);
    cmp("wbAck", 32'h0, {31'h0, wbAck});
  endtask : wb

  task automatic give_verdict();
    $display("num_errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Cuts a hang short well after the sequence should have ended.
  initial
  begin
    tick(9000);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    rst = 1'b1;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatWr, busDp, busDm, strapDrive} = '0;
    wbSel = 4'hF;
    supplyOk = 1'b1;
    num_errors = 0;
    checks = 0;
    tick(4);
    rst <= 1'b0;
    // Power-on pulse keeps the line drivers off although enabled.
    usb_ctrl_model_inst.send(1'b1, 1'b0);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    cmp("por", 32'h1, rd[STAT_POR_BIT]);
    cmp("devReset", 32'h1, rd[STAT_DEV_RESET_BIT]);
    cmp("dpOe", 32'h0, dpOe);
    tick(60);
    wb(1'b0, CTRL_OFFSET, 32'h0);
    cmp("ctrl", {28'h0, CTRL_RESET}, rd);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    cmp("por", 32'h0, rd[STAT_POR_BIT]);
    cmp("devReset", 32'h0, rd[STAT_DEV_RESET_BIT]);
    cmp("rxStatus", 32'h1, rd[STAT_RECEIVE_BIT]);
    cmp("select", 32'h0, rd[STAT_ADDR_SEL_BIT]);
    cmp("busAddr", {25'h0, BUS_ADDR_BASE}, rd[STAT_BUS_ADDR_LSB +: 7]);
    // Transmit table over suspend, mode, data and force-zero.
    for (int i = 0; i < 16; i++)
    begin
      wb(1'b1, CTRL_OFFSET, {30'h0, i[3], i[2]});
      usb_ctrl_model_inst.send(i[1], i[0]);
      tick(3);
      cmp("dpOe", 32'h1, dpOe);
      cmp("dpOut", i[3] ? i[1] : i[2] && i[0] ? 1'b0 : i[1], dpOut);
      cmp("dmOut", i[3] ? i[1] : i[2] ? !i[1] && !i[0] : i[0], dmOut);
    end
    fork
      usb_ctrl_model_inst.reset_pulse();
      begin
        tick(3);
        cmp("dpOe", 32'h0, dpOe);
      end
    join
    busDp <= 1'b1;
    wb(1'b1, CTRL_OFFSET, 32'h0);
    usb_ctrl_model_inst.release_bus();
    tick(2);
    diff_receive_out = 1'b1;
    cmp("dmOe", 32'h0, dmOe);
    cmp("dataPinOe", 32'h1, dataOrPlusPinOe);
    // Receive table over suspend, mode and both line levels.
    for (int i = 0; i < 16; i++)
    begin
      wb(1'b1, CTRL_OFFSET, {30'h0, i[3], i[2]});
      busDp <= i[1];
      busDm <= i[0];
      tick(3);
      if (!i[3] && i[1] != i[0])
        diff_receive_out = i[1];
      cmp("dataPin", i[2] && !i[3] ? diff_receive_out : i[1], dataOrPlusPinOut);
      cmp("zeroPin", i[2] ? !i[1] && !i[0] : i[0], zeroOrMinusPinOut);
      if (!i[3])
        cmp("receive", diff_receive_out, diffReceiveOut);
    end
    // Pump switch enable and polarity before and after the strap is taken.
    wb(1'b1, CTRL_OFFSET, 32'h0000000C);
    tick(2);
    cmp("pumpOe", 32'h1, addrStrapSwitchPinOe);
    cmp("pumpOut", 32'h1, addrStrapSwitchPinOut);
    wb(1'b1, CTRL_OFFSET, 32'h00000008);
    tick(2);
    cmp("pumpOe", 32'h0, addrStrapSwitchPinOe);
    strapDrive <= 1'b1;
    usb_ctrl_model_inst.reset_pulse();
    tick(3);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    cmp("select", 32'h1, rd[STAT_ADDR_SEL_BIT]);
    cmp("busAddr", {25'h0, BUS_ADDR_BASE | 7'h01}, rd[STAT_BUS_ADDR_LSB +: 7]);
    wb(1'b1, CTRL_OFFSET, 32'h0000000C);
    tick(2);
    cmp("pumpOut", 32'h0, addrStrapSwitchPinOut);
    wb(1'b0, 8'h08, 32'h0);
    cmp("unmapped", 32'h0, rd);
    // A short supply dip is ignored, a long one restarts the pulse.
    supplyOk <= 1'b0;
    tick(100);
    supplyOk <= 1'b1;
    tick(3);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    cmp("por", 32'h0, rd[STAT_POR_BIT]);
    cmp("select", 32'h1, rd[STAT_ADDR_SEL_BIT]);
    supplyOk <= 1'b0;
    tick(2800);
    supplyOk <= 1'b1;
    tick(3);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    cmp("por", 32'h1, rd[STAT_POR_BIT]);
    tick(60);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    cmp("select", 32'h0, rd[STAT_ADDR_SEL_BIT]);
    give_verdict();
  end
endmodule : tb_top
